// file: inc/system_reset_status_defines.vh
// Constants of the reset cause, forced reset and write-once options block.
// Assumes a single bus clock of 125 MHz and an 8-bit register access port.
`ifndef SYSTEM_RESET_STATUS_DEFINES_VH
`define SYSTEM_RESET_STATUS_DEFINES_VH

// Register addresses on the local access port
`define ADDR_W 2
`define ADDR_RESET_CAUSE 2'h0
`define ADDR_DEBUG_FORCE 2'h1
`define ADDR_OPTIONS 2'h2

// Cause register bit positions
`define CAUSE_POWER_ON 7
`define CAUSE_PIN 6
`define CAUSE_WATCHDOG 5
`define CAUSE_ILLEGAL 4
`define CAUSE_CLOCK_GEN 2
`define CAUSE_LOW_VOLTAGE 1
`define CAUSE_POWER_ON_VALUE 8'h82
`define CAUSE_CLEAR_VALUE 8'h00

// Forced reset register
`define FORCE_RESET_BIT 0
`define FORCE_READ_VALUE 8'h00

// Options register fields
`define OPT_WATCHDOG_ENABLE 7
`define OPT_LONG_TIMEOUT 6
`define OPT_STOP_ALLOWED 5
`define OPT_DEBUG_PIN 1
`define OPT_RESET_VALUE 8'hc2
`define OPT_WRITE_MASK 8'he2

// Watchdog periods as powers of two of the bus clock
`define WDOG_LOG2_W 5
`define WDOG_SHORT_LOG2 5'h0d
`define WDOG_LONG_LOG2 5'h12

// Least hold time of a system reset
`define RESET_HOLD_NS 128
`define CLOCK_PERIOD_NS 8
`define RESET_HOLD_CYCLES ((`RESET_HOLD_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// file: rtl/reset_hold_timer.v
// Holds a system reset for a minimum number of bus clocks.
// Assumes the load request is synchronous to the bus clock.
`include "system_reset_status_defines.vh"

module reset_hold_timer #(
  parameter HOLD_CYCLES = `RESET_HOLD_CYCLES,
  parameter CNT_W = 8
) (
  input wire mclk_in,
  input wire resetn_in,
  input wire load_in,
  output wire busy_out,
  output reg expire_out
);

  localparam [CNT_W-1:0] LOAD_VALUE = HOLD_CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  reg [CNT_W-1:0] count_q;
  reg [CNT_W-1:0] count_d;

  // Reload while any source stays asserted, so a long pin pulse stretches it
  always @* begin
    count_d = count_q;
    if (load_in) begin
      count_d = LOAD_VALUE;
    end else if (count_q != {CNT_W{1'b0}}) begin
      count_d = count_q - ONE;
    end
  end

  // Counter and one-cycle expiry strobe
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_q <= {CNT_W{1'b0}};
      expire_out <= 1'b0;
    end else begin
      count_q <= count_d;
      expire_out <= (count_q == ONE) && !load_in;
    end
  end

  assign busy_out = (count_q != {CNT_W{1'b0}});

endmodule // reset_hold_timer

// file: rtl/system_reset_status.v
// Reset cause capture, debug forced reset and write-once system options.
// Assumes resetn_in is the power-on reset; every other reset source is a
// synchronous request that this block turns into system_reset_out.
`include "system_reset_status_defines.vh"

module system_reset_status #(
  parameter HOLD_CYCLES = `RESET_HOLD_CYCLES,
  parameter HOLD_CNT_W = 8
) (
  input wire mclk_in,
  input wire resetn_in,
  // Register access port
  input wire [`ADDR_W-1:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_wdata_in,
  input wire debug_access_in,
  output reg [7:0] reg_rdata_out,
  // Reset sources
  input wire ext_reset_n_in,
  input wire wdog_timeout_in,
  input wire illegal_opcode_in,
  input wire stop_exec_in,
  input wire background_exec_in,
  input wire background_mode_enable_in,
  input wire clock_generator_reset_in,
  input wire low_voltage_in,
  input wire low_voltage_detect_enable_in,
  input wire low_voltage_reset_enable_in,
  input wire low_voltage_stop_enable_in,
  input wire stop_mode_in,
  // Controls to the rest of the chip
  output reg system_reset_out,
  output reg wdog_restart_out,
  output reg stop_entry_out,
  output reg low_voltage_monitor_on_out,
  output reg watchdog_enable_out,
  output reg watchdog_long_timeout_out,
  output reg [`WDOG_LOG2_W-1:0] wdog_period_log2_out,
  output reg stop_allowed_out,
  output reg debug_pin_enable_out
);

  // Sequencer states
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_HOLD = 2'h1;
  localparam [1:0] ST_RELEASE = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] cause_q;
  reg [7:0] cause_d;
  reg [7:0] options_q;
  reg [7:0] options_d;
  reg options_written_q;
  reg options_written_d;
  reg force_q;
  reg force_d;

  wire hold_busy;
  wire hold_expire;

  // Address match, used by every register write decode; the read path decodes with a case
  function addr_hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Watchdog period exponent from the timeout option
  function [`WDOG_LOG2_W-1:0] wdog_log2;
    input long_sel;
    begin
      wdog_log2 = long_sel ? `WDOG_LONG_LOG2 : `WDOG_SHORT_LOG2;
    end
  endfunction

  // Register writes are ignored while a system reset is being held
  wire in_run = (state_q == ST_RUN);
  wire wr_cause = reg_wr_in && in_run && addr_hit(reg_addr_in, `ADDR_RESET_CAUSE);
  wire wr_force = reg_wr_in && in_run && addr_hit(reg_addr_in, `ADDR_DEBUG_FORCE);
  wire wr_options = reg_wr_in && in_run && addr_hit(reg_addr_in, `ADDR_OPTIONS);

  // Option fields as seen by the reset sources
  wire opt_wdog_en = options_q[`OPT_WATCHDOG_ENABLE];
  wire opt_stop_ok = options_q[`OPT_STOP_ALLOWED];

  // Detector is powered only when enabled, and in stop only if kept alive
  wire lv_monitor_on = low_voltage_detect_enable_in &&
                       (!stop_mode_in || low_voltage_stop_enable_in);

  // Individual reset requests
  wire src_pin = !ext_reset_n_in;
  wire src_wdog = wdog_timeout_in && opt_wdog_en;
  wire stop_illegal = stop_exec_in && !opt_stop_ok;
  wire background_instruction_illegal = background_exec_in && !background_mode_enable_in;
  wire src_illegal = illegal_opcode_in || stop_illegal || background_instruction_illegal;
  wire src_clock_gen = clock_generator_reset_in;
  wire src_low_voltage = low_voltage_in && lv_monitor_on &&
                         low_voltage_reset_enable_in;
  wire src_force = force_q;

  wire any_source = src_pin || src_wdog || src_illegal || src_clock_gen ||
                    src_low_voltage || src_force;

  // Cause byte for a reset taken now; bits 3 and 0 stay zero
  function [7:0] cause_byte;
    input pin;
    input wdog;
    input illegal_opcode_flag;
    input clkg;
    input lv;
    input por_prev;
    reg [7:0] v;
    begin
      v = `CAUSE_CLEAR_VALUE;
      v[`CAUSE_PIN] = pin;
      v[`CAUSE_WATCHDOG] = wdog;
      v[`CAUSE_ILLEGAL] = illegal_opcode_flag;
      v[`CAUSE_CLOCK_GEN] = clkg;
      v[`CAUSE_LOW_VOLTAGE] = lv;
      // Power-on flag survives only a low-voltage reset
      v[`CAUSE_POWER_ON] = lv & por_prev;
      cause_byte = v;
    end
  endfunction

  // Sequencer: run, hold the system in reset, then one release cycle
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (any_source) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!hold_busy && !any_source) begin
          state_d = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        state_d = any_source ? ST_HOLD : ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // Cause capture at the moment a reset is taken
  always @* begin
    cause_d = cause_q;
    if (in_run && any_source) begin
      // A forced reset adds no flag of its own, so alone it reads all clear
      cause_d = cause_byte(src_pin, src_wdog, src_illegal, src_clock_gen,
                           src_low_voltage, cause_q[`CAUSE_POWER_ON]);
    end
    // A write to this address never changes the flags
  end

  // Write-once options; every reset restores defaults and re-arms the write
  always @* begin
    options_d = options_q;
    options_written_d = options_written_q;
    if (in_run && any_source) begin
      options_d = `OPT_RESET_VALUE;
      options_written_d = 1'b0;
    end else if (wr_options && !options_written_q) begin
      options_d = reg_wdata_in & `OPT_WRITE_MASK;
      options_written_d = 1'b1;
    end
  end

  // Forced reset request: only a background debug write can set it
  always @* begin
    force_d = 1'b0;
    if (wr_force && debug_access_in && reg_wdata_in[`FORCE_RESET_BIT]) begin
      force_d = 1'b1;
    end
  end

  // State and register flops
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_RUN;
      cause_q <= `CAUSE_POWER_ON_VALUE;
      options_q <= `OPT_RESET_VALUE;
      options_written_q <= 1'b0;
      force_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
      options_q <= options_d;
      options_written_q <= options_written_d;
      force_q <= force_d;
    end
  end

  // Minimum hold of the system reset, stretched by lingering sources
  reset_hold_timer #(
    .HOLD_CYCLES(HOLD_CYCLES),
    .CNT_W(HOLD_CNT_W)
  ) u_hold (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .load_in(any_source),
    .busy_out(hold_busy),
    .expire_out()
  );

  // Read data, registered one cycle after the read strobe
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `ADDR_RESET_CAUSE: begin
          reg_rdata_out <= cause_q;
        end
        `ADDR_DEBUG_FORCE: begin
          reg_rdata_out <= `FORCE_READ_VALUE;
        end
        `ADDR_OPTIONS: begin
          reg_rdata_out <= options_q;
        end
        default: begin
          reg_rdata_out <= 8'h00;
        end
      endcase
    end
  end

  // Control outputs, all from flops; the watchdog pulse lasts one cycle
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      system_reset_out <= 1'b1;
      wdog_restart_out <= 1'b0;
      stop_entry_out <= 1'b0;
      low_voltage_monitor_on_out <= 1'b0;
      watchdog_enable_out <= 1'b1;
      watchdog_long_timeout_out <= 1'b1;
      wdog_period_log2_out <= `WDOG_LONG_LOG2;
      stop_allowed_out <= 1'b0;
      debug_pin_enable_out <= 1'b1;
    end else begin
      // Released one cycle after the sequencer leaves the hold
      system_reset_out <= (state_d != ST_RUN);
      wdog_restart_out <= wr_cause;
      stop_entry_out <= stop_exec_in && opt_stop_ok && in_run;
      low_voltage_monitor_on_out <= lv_monitor_on;
      watchdog_enable_out <= options_d[`OPT_WATCHDOG_ENABLE];
      watchdog_long_timeout_out <= options_d[`OPT_LONG_TIMEOUT];
      wdog_period_log2_out <= wdog_log2(options_d[`OPT_LONG_TIMEOUT]);
      stop_allowed_out <= options_d[`OPT_STOP_ALLOWED];
      debug_pin_enable_out <= options_d[`OPT_DEBUG_PIN];
    end
  end

endmodule // system_reset_status

// file: verif/reset_source_model.sv
// Stand-in for the on-chip reset sources around the block.
// Assumes fire is called just after a rising edge of the bus clock.
module reset_source_model (
  input logic mclk_in,
  output logic ext_reset_n_out,
  output logic [5:0] req_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet sources from time zero
  initial begin
    ext_reset_n_out = 1'b1;
    req_out = 6'h00;
  end

  // One source for exactly one sampling edge; pin is active low
  task automatic fire(input int k);
    if (k == 0) ext_reset_n_out = 1'b0;
    else req_out[k-1] = 1'b1;
    @(posedge mclk_in);
    #1;
    ext_reset_n_out = 1'b1;
    req_out = 6'h00;
  endtask
endmodule // reset_source_model

// file: verif/system_reset_status_properties.sv
// Port-level checks of the reset cause and write-once options block.
// Assumes one bus clock and resetn_in as the only asynchronous reset.
module system_reset_status_checker (
  input logic mclk_in,
  input logic resetn_in,
  input logic [1:0] reg_addr_in,
  input logic reg_wr_in,
  input logic reg_rd_in,
  input logic [7:0] reg_wdata_in,
  input logic debug_access_in,
  input logic [7:0] reg_rdata_out,
  input logic wdog_timeout_in,
  input logic stop_exec_in,
  input logic system_reset_out,
  input logic wdog_restart_out,
  input logic stop_entry_out,
  input logic watchdog_enable_out,
  input logic watchdog_long_timeout_out,
  input logic [4:0] wdog_period_log2_out,
  input logic stop_allowed_out,
  input logic debug_pin_enable_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  // Restart pulse is exactly one cycle after a cause write
  restart_pulse_a: assert property (reg_wr_in && reg_addr_in == 2'h0 && !system_reset_out
    |=> wdog_restart_out ##1 !wdog_restart_out) else $error("restart pulse wrong");
  restart_cause_a: assert property (wdog_restart_out
    |-> $past(reg_wr_in) && $past(reg_addr_in) == 2'h0) else $error("restart without write");
  // Read-back of fixed zero places
  cause_zero_bits_a: assert property (reg_rd_in && reg_addr_in == 2'h0
    |=> reg_rdata_out[3] == 1'b0 && reg_rdata_out[0] == 1'b0) else $error("cause pad bits");
  force_reads_zero_a: assert property (reg_rd_in && reg_addr_in == 2'h1
    |=> reg_rdata_out == 8'h00) else $error("forced reset reads nonzero");
  option_zero_bits_a: assert property (reg_rd_in && reg_addr_in == 2'h2
    |=> (reg_rdata_out & 8'h1d) == 8'h00) else $error("option pad bits");
  // Forced reset only from a debug write of bit 0; gated watchdog and stop; period select
  user_force_ignored_a: assert property (reg_wr_in && reg_addr_in == 2'h1 &&
    !(debug_access_in && reg_wdata_in[0]) && !system_reset_out |=> !system_reset_out [*3])
    else $error("program write forced reset");
  debug_force_a: assert property (reg_wr_in && reg_addr_in == 2'h1 && debug_access_in &&
    reg_wdata_in[0] && !system_reset_out |-> ##[1:3] system_reset_out)
    else $error("debug force gave no reset");
  wdog_blocked_a: assert property (wdog_timeout_in && !watchdog_enable_out &&
    !system_reset_out |=> !system_reset_out [*3]) else $error("disabled watchdog reset");
  stop_refused_a: assert property (stop_exec_in && !stop_allowed_out
    |=> !stop_entry_out) else $error("stop entered while refused");
  period_select_a: assert property (wdog_period_log2_out ==
    (watchdog_long_timeout_out ? 5'h12 : 5'h0d)) else $error("watchdog period wrong");
  // Settled system reset carries the option defaults
  option_defaults_a: assert property (system_reset_out && $past(system_reset_out)
    |-> watchdog_enable_out && watchdog_long_timeout_out && debug_pin_enable_out
    && !stop_allowed_out) else $error("option defaults wrong");
endmodule // system_reset_status_checker

bind system_reset_status system_reset_status_checker u_chk (.*);

// file: verif/test_system_reset_status.sv
// Self-checking bench for the reset cause and write-once options block.
// Assumes a short reset hold parameter; sources come from the source model.
module test_system_reset_status;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in = 1'b0, resetn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic debug_access_in = 1'b0, bg_en = 1'b0, lv_re = 1'b1, stop_mode = 1'b0;
  logic lv_de = 1'b1, lv_se = 1'b0;
  logic stop_entry, mon_on, wd_en, wd_long, stop_ok, dbg_pin;
  logic [4:0] period;
  logic [1:0] reg_addr_in = 2'h0;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out;
  logic sys_rst, restart, ext_n;
  logic [5:0] req;
  int err_total = 0, n_tests = 0;

  // Bus clock at 125 MHz
  always #4 mclk_in = ~mclk_in;

  reset_source_model u_src (.mclk_in(mclk_in), .ext_reset_n_out(ext_n), .req_out(req));

  system_reset_status #(.HOLD_CYCLES(2)) u_dut (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .debug_access_in(debug_access_in), .reg_rdata_out(reg_rdata_out),
    .ext_reset_n_in(ext_n), .wdog_timeout_in(req[0]), .illegal_opcode_in(req[1]),
    .clock_generator_reset_in(req[2]), .low_voltage_in(req[3]), .stop_exec_in(req[4]),
    .background_exec_in(req[5]), .background_mode_enable_in(bg_en),
    .low_voltage_detect_enable_in(lv_de), .low_voltage_reset_enable_in(lv_re),
    .low_voltage_stop_enable_in(lv_se), .stop_mode_in(stop_mode),
    .system_reset_out(sys_rst), .wdog_restart_out(restart), .stop_entry_out(stop_entry),
    .low_voltage_monitor_on_out(mon_on), .watchdog_enable_out(wd_en),
    .watchdog_long_timeout_out(wd_long), .wdog_period_log2_out(period),
    .stop_allowed_out(stop_ok), .debug_pin_enable_out(dbg_pin));

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic dbg);
    reg_addr_in = a;
    reg_wdata_in = d;
    debug_access_in = dbg;
    reg_wr_in = 1'b1;
    tick();
    reg_wr_in = 1'b0;
    debug_access_in = 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    tick();
    reg_rd_in = 1'b0;
    d = reg_rdata_out;
  endtask

  // Bounded watch for a system reset pulse; a stuck reset ends the run
  task automatic ride_reset(input logic want);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 40; i++) begin
      tick();
      if (sys_rst === 1'b1) seen = 1'b1;
      if (seen && sys_rst === 1'b0) break;
    end
    chk({7'h00, seen}, {7'h00, want}, "reset seen");
    if (sys_rst !== 1'b0) begin
      err_total++;
      tally_and_finish();
    end
    tick(2);
  endtask

  // Cause byte for one source; only low voltage keeps the power-on flag
  function automatic logic [7:0] exp_cause(input int k, input logic por);
    case (k)
      0: return 8'h40;
      1: return 8'h20;
      2, 5, 6: return 8'h10;
      3: return 8'h04;
      4: return {por, 7'h02};
      default: return 8'h00;
    endcase
  endfunction

  initial begin
    int k, seed;
    logic [7:0] d, o;
    logic por;
    seed = $urandom(86068);
    repeat (5) @(posedge mclk_in);
    #1 resetn_in = 1'b1;
    tick(2);
    rd(2'h0, d); chk(d, 8'h82, "power-on cause");
    rd(2'h2, d); chk(d, 8'hc2, "option defaults");
    rd(2'h1, d); chk(d, 8'h00, "forced reads");
    rd(2'h3, d); chk(d, 8'h00, "unmapped");
    chk({4'h0, wd_en, wd_long, stop_ok, dbg_pin}, 8'h0d, "option outs");
    chk({3'h0, period}, 8'h12, "long period");
    chk({7'h00, mon_on}, 8'h01, "monitor on");
    wr(2'h0, 8'($urandom), 1'b0); chk({7'h00, restart}, 8'h01, "restart");
    tick(); chk({7'h00, restart}, 8'h00, "restart end");
    rd(2'h0, d); chk(d, 8'h82, "cause kept");
    wr(2'h1, 8'hff, 1'b0); ride_reset(1'b0);
    wr(2'h1, 8'hfe, 1'b1); ride_reset(1'b0);
    lv_re = 1'b0; u_src.fire(4); ride_reset(1'b0); lv_re = 1'b1;
    stop_mode = 1'b1; u_src.fire(4); chk({7'h00, mon_on}, 8'h00, "monitor off");
    ride_reset(1'b0);
    lv_se = 1'b1; u_src.fire(4); ride_reset(1'b1); stop_mode = 1'b0; lv_se = 1'b0;
    rd(2'h0, d); chk(d, 8'h82, "stop kept detect");
    lv_de = 1'b0; u_src.fire(4); ride_reset(1'b0); lv_de = 1'b1;
    // Every source once, low voltage first, then random picks
    por = 1'b1;
    for (int i = 0; i < 20; i++) begin
      k = (i < 8) ? (i + 4) % 8 : int'($urandom % 8);
      if (k == 7) wr(2'h1, 8'h01, 1'b1);
      else u_src.fire(k);
      ride_reset(1'b1);
      rd(2'h0, d); chk(d, exp_cause(k, por), "cause");
      rd(2'h2, d); chk(d, 8'hc2, "options reset");
      if (k != 4) por = 1'b0;
    end
    // Start-up code writes options once; a second write must be ignored
    o = 8'($urandom) & 8'h7f;
    wr(2'h2, o, 1'b0);
    wr(2'h2, ~o, 1'b0);
    rd(2'h2, d); chk(d, o & 8'he2, "write once");
    chk({4'h0, wd_en, wd_long, stop_ok, dbg_pin}, {4'h0, o[7], o[6], o[5], o[1]}, "outs");
    chk({3'h0, period}, o[6] ? 8'h12 : 8'h0d, "period");
    u_src.fire(1); ride_reset(1'b0);
    bg_en = 1'b1; u_src.fire(6); ride_reset(1'b0); bg_en = 1'b0;
    u_src.fire(5); chk({7'h00, stop_entry}, {7'h00, o[5]}, "stop entry");
    ride_reset(~o[5]);
    tally_and_finish();
  end
endmodule // test_system_reset_status
